//--- rtl/atf_pkg.sv
// Package for the device task-file register block: addresses, field layout, resets, timing.
// Assumes a 50 MHz device clock and a register port driven by the link layer.
package atf_pkg;

	// ************************************************************
	// Register addresses on the task-file port
	// ************************************************************
	localparam logic [3:0] ADDR_DATA_PORT        = 4'h0;
	localparam logic [3:0] ADDR_ERROR_REPORT     = 4'h1;
	localparam logic [3:0] ADDR_TRANSFER_COUNT   = 4'h2;
	localparam logic [3:0] ADDR_SECTOR_NUMBER    = 4'h3;
	localparam logic [3:0] ADDR_ADDRESS_MIDDLE   = 4'h4;
	localparam logic [3:0] ADDR_ADDRESS_UPPER    = 4'h5;
	localparam logic [3:0] ADDR_DRIVE_HEAD       = 4'h6;
	localparam logic [3:0] ADDR_STATUS           = 4'h7;
	localparam logic [3:0] ADDR_MIRROR_STATUS    = 4'hE;
	// Write side aliases of shared addresses
	localparam logic [3:0] ADDR_COMMAND_PARAM    = 4'h1;
	localparam logic [3:0] ADDR_COMMAND_CODE     = 4'h7;
	localparam logic [3:0] ADDR_INTERFACE_CTRL   = 4'hE;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_HIGH_BYTE_BIT   = 7;
	localparam int CTRL_SOFT_RESET_BIT  = 2;
	localparam int CTRL_IRQ_DISABLE_BIT = 1;
	localparam int HEAD_ADDR_MODE_BIT   = 6;
	localparam int HEAD_DRIVE_BIT       = 4;

	localparam logic [7:0] HEAD_FORCED_ONES  = 8'hA0;
	localparam logic [7:0] ERROR_VALID_MASK  = 8'hD6;

	localparam int ERR_CRC_BIT    = 7;
	localparam int ERR_UNCORR_BIT = 6;
	localparam int ERR_IDNF_BIT   = 4;
	localparam int ERR_ABORT_BIT  = 2;
	localparam int ERR_TRACK0_BIT = 1;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] RESET_STATUS      = 8'h50;
	localparam logic [7:0] RESET_COUNT       = 8'h01;
	localparam logic [7:0] RESET_SECTOR      = 8'h01;
	localparam logic [7:0] RESET_ADDRESS     = 8'h00;
	localparam logic [7:0] RESET_DRIVE_HEAD  = 8'h00;
	localparam logic [7:0] DIAG_NO_ERROR     = 8'h01;
	localparam logic [7:0] POWER_IDLE_LEGACY = 8'h80;
	localparam logic [7:0] POWER_IDLE_EPC_OFF = 8'hFF;

	// ************************************************************
	// Command codes handled locally
	// ************************************************************
	localparam logic [7:0] CMD_CHECK_POWER   = 8'hE5;
	localparam logic [7:0] CMD_DOWNLOAD_PIO  = 8'h92;
	localparam logic [7:0] CMD_DOWNLOAD_DMA  = 8'h93;
	localparam logic [7:0] CMD_DIAGNOSTIC    = 8'h90;

	// ************************************************************
	// Timing, in units as printed, then in cycles
	// ************************************************************
	localparam int CLK_HZ             = 50_000_000;
	localparam int COMINIT_NORMAL_MS  = 10;
	localparam int POR_GRACE_MS       = 500;
	localparam int STREAM_MIN_MS      = 50;
	localparam int RECOVERY_MIN_100MS = 65;
	localparam int COMINIT_NORMAL_CYC = COMINIT_NORMAL_MS * (CLK_HZ / 1000);
	localparam int POR_GRACE_CYC      = POR_GRACE_MS * (CLK_HZ / 1000);

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] sector;
		logic [7:0] addrMiddle;
		logic [7:0] addrUpper;
		logic [7:0] driveHead;
	} atf_addr_t;

	typedef struct packed {
		logic       success;
		logic [7:0] errorBits;
		logic [7:0] statusBits;
		atf_addr_t  final_;
	} atf_done_t;

endpackage : atf_pkg

//--- rtl/atf_task_file.sv
// Device-side task-file register set: host port, 48-bit history, status, limits.
// Assumes the link layer presents host accesses as one-cycle strobes on clk.
//
// Notes on behaviour
// [R1] Idle power query reports FFh with EPC off
// [R2] Microcode download aborted while security locked
// [R3] Late reset answer allowed in first 500ms
// [R4] Streaming limit raised to at least 50ms
// [R5] Recovery limit under 6.5s aborts command
// [R6] Host sets busy and sends register frame
// [R7] Mirror status read leaves interrupt pending
// [R8] Command write starts execution immediately
// [R9] Upper address byte: LBA 16-23, history 40-47
// [R10] Middle address byte: LBA 8-15, history 32-39
// [R11] High-byte select; command-block writes clear it
// [R12] Soft reset bit holds device in reset
// [R13] Host holds soft reset at least 5us
// [R14] Interrupt only when enabled and selected
// [R15] Address mode bit; bits 7,5 forced one
// [R16] Head bits: head or LBA 24-27, updated
// [R17] Error valid after commands; diagnostic after reset
// [R18] Error bits CRC, UNC, IDNF, ABRT, TK0
// [R19] Address-mark error bit always zero
// [R20] Zero count means 256 or 65536
// [R21] Count zero on success, remainder on failure
// [R22] Parameter register passed per command
// [R23] Status bit layout; others invalid while busy
// [R24] Status read acknowledges pending interrupt
// [R25] Reset defaults: 50h, 01h, 01h, 00h
// [R26] Completion reloads registers and clears busy
`timescale 1ns/1ps

module atf_task_file #(
	parameter int GRACE_CYCLES   = atf_pkg::POR_GRACE_CYC,
	parameter int COMINIT_CYCLES = atf_pkg::COMINIT_NORMAL_CYC
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              linkReset,
	input  wire logic              hostWrite,
	input  wire logic              hostRead,
	input  wire logic [3:0]        hostAddr,
	input  wire logic [7:0]        hostWdata,
	output logic      [7:0]        hostRdata,
	input  wire logic              epcEnabled,
	input  wire logic              deviceIdle,
	input  wire logic              securityLocked,
	input  wire logic              spinningUp,
	input  wire logic [15:0]       streamLimitMs,
	input  wire logic [7:0]        recoveryLimit100ms,
	input  wire logic              recoveryLimitGiven,
	input  wire logic              cmdDone,
	input  wire atf_pkg::atf_done_t cmdResult,
	input  wire logic [7:0]        diagCode,
	input  wire logic              deviceSelected,
	output logic                   cmdStart,
	output logic      [7:0]        cmdCode,
	output logic      [7:0]        cmdParam,
	output atf_pkg::atf_addr_t     cmdAddr,
	output logic      [16:0]       sectorsRequested,
	output logic                   lbaMode,
	output logic      [15:0]       streamLimitUsedMs,
	output logic                   spinupOverrun,
	output logic                   inSoftReset,
	output logic                   intrq,
	output logic                   cominitLateOk,
	output logic                   frameToHost
);

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [1:0] {
		ATF_IDLE = 2'b00,
		ATF_BUSY = 2'b01,
		ATF_RST  = 2'b10
	} atf_state_t;

	atf_state_t         state_reg, state_next;
	atf_pkg::atf_addr_t cur_reg, prev_reg;
	logic [7:0]         status_reg, error_reg, ctrl_reg, feat_reg, prevFeat_reg, code_reg;
	logic               pend_reg, frame_reg, start_reg;
	logic [$clog2(GRACE_CYCLES+1)-1:0] grace_reg;

	// ************************************************************
	// Decode
	// ************************************************************
	wire logic anyReset   = reset | linkReset;
	wire logic hob        = ctrl_reg[atf_pkg::CTRL_HIGH_BYTE_BIT];
	wire logic srst       = ctrl_reg[atf_pkg::CTRL_SOFT_RESET_BIT];
	wire logic wrCtrl     = hostWrite && hostAddr == atf_pkg::ADDR_INTERFACE_CTRL;
	wire logic wrCmd      = hostWrite && hostAddr == atf_pkg::ADDR_COMMAND_CODE;
	wire logic wrBlock    = hostWrite && hostAddr != atf_pkg::ADDR_INTERFACE_CTRL
	                        && hostAddr != atf_pkg::ADDR_DATA_PORT;
	wire logic rdStatus   = hostRead && hostAddr == atf_pkg::ADDR_STATUS;
	wire logic busy       = status_reg[7];

	// [R2] Locked download
	wire logic abortLock  = securityLocked && (hostWdata == atf_pkg::CMD_DOWNLOAD_PIO
	                        || hostWdata == atf_pkg::CMD_DOWNLOAD_DMA);
	// [R5] Recovery floor
	wire logic abortLimit = recoveryLimitGiven
	                        && recoveryLimit100ms < 8'(atf_pkg::RECOVERY_MIN_100MS);
	// [R1] Power query answer
	wire logic powerQuery = hostWdata == atf_pkg::CMD_CHECK_POWER;
	wire logic [7:0] powerAnswer = (!epcEnabled && deviceIdle) ?
	                        atf_pkg::POWER_IDLE_EPC_OFF : atf_pkg::POWER_IDLE_LEGACY;

	function automatic logic [7:0] pick(input logic h, input logic [7:0] c, input logic [7:0] p);
		pick = h ? p : c;
	endfunction : pick

	// ************************************************************
	// Read mux
	// ************************************************************
	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		// [R23] Busy shows status at every address but the data port
		if (busy && hostAddr != atf_pkg::ADDR_DATA_PORT) begin
			rdMux = status_reg;
		end else begin
			unique case (hostAddr)
				// [R18] Valid error bits
				atf_pkg::ADDR_ERROR_REPORT:   rdMux = error_reg;
				atf_pkg::ADDR_TRANSFER_COUNT: rdMux = pick(hob, cur_reg.count, prev_reg.count);
				atf_pkg::ADDR_SECTOR_NUMBER:  rdMux = pick(hob, cur_reg.sector, prev_reg.sector);
				// [R10] Middle byte history
				atf_pkg::ADDR_ADDRESS_MIDDLE:
					rdMux = pick(hob, cur_reg.addrMiddle, prev_reg.addrMiddle);
				// [R9] Upper byte history
				atf_pkg::ADDR_ADDRESS_UPPER:
					rdMux = pick(hob, cur_reg.addrUpper, prev_reg.addrUpper);
				// [R15] Forced ones
				atf_pkg::ADDR_DRIVE_HEAD:     rdMux = cur_reg.driveHead | atf_pkg::HEAD_FORCED_ONES;
				// [R7] Same bits, no acknowledge
				atf_pkg::ADDR_STATUS,
				atf_pkg::ADDR_MIRROR_STATUS:  rdMux = status_reg;
				default:                      rdMux = 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ATF_IDLE: begin
				if (srst) state_next = ATF_RST;
				else if (wrCmd && !(abortLock || abortLimit || powerQuery)) state_next = ATF_BUSY;
			end
			ATF_BUSY: begin
				if (srst) state_next = ATF_RST;
				else if (cmdDone) state_next = ATF_IDLE;
			end
			// [R12] Held until bit clears
			ATF_RST: begin
				if (!srst) state_next = ATF_IDLE;
			end
			default: state_next = ATF_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		hostRdata <= hostRead ? rdMux : hostRdata;
		if (anyReset) begin
			state_reg <= ATF_IDLE;
			ctrl_reg  <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (wrCtrl) ctrl_reg <= hostWdata;
			// [R11] Block write clears select
			else if (wrBlock) ctrl_reg[atf_pkg::CTRL_HIGH_BYTE_BIT] <= 1'b0;
		end
		// Only power-on restarts the window; a link reset must not reopen it
		if (reset) grace_reg <= '0;
		else if (grace_reg != $bits(grace_reg)'(GRACE_CYCLES)) grace_reg <= grace_reg + 1'b1;
	end

	// Registers reset also by soft reset
	wire logic regReset = anyReset || state_reg == ATF_RST;

	always_ff @(posedge clk) begin
		if (regReset) begin
			// [R25] Defaults
			cur_reg      <= '{atf_pkg::RESET_COUNT, atf_pkg::RESET_SECTOR, atf_pkg::RESET_ADDRESS,
			                  atf_pkg::RESET_ADDRESS, atf_pkg::RESET_DRIVE_HEAD};
			prev_reg     <= '0;
			status_reg   <= atf_pkg::RESET_STATUS;
			// [R17] Diagnostic code after reset
			error_reg    <= reset ? atf_pkg::DIAG_NO_ERROR : diagCode;
			feat_reg     <= 8'h00;
			prevFeat_reg <= 8'h00;
			code_reg     <= 8'h00;
			pend_reg     <= 1'b0;
			start_reg    <= 1'b0;
			frame_reg    <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			frame_reg <= 1'b0;
			if (wrBlock && !wrCmd) begin
				unique case (hostAddr)
					// [R22] Parameter byte kept
					atf_pkg::ADDR_COMMAND_PARAM: begin
						prevFeat_reg <= feat_reg; feat_reg <= hostWdata;
					end
					atf_pkg::ADDR_TRANSFER_COUNT: begin
						prev_reg.count <= cur_reg.count; cur_reg.count <= hostWdata;
					end
					atf_pkg::ADDR_SECTOR_NUMBER: begin
						prev_reg.sector <= cur_reg.sector; cur_reg.sector <= hostWdata;
					end
					atf_pkg::ADDR_ADDRESS_MIDDLE: begin
						prev_reg.addrMiddle <= cur_reg.addrMiddle; cur_reg.addrMiddle <= hostWdata;
					end
					atf_pkg::ADDR_ADDRESS_UPPER: begin
						prev_reg.addrUpper <= cur_reg.addrUpper; cur_reg.addrUpper <= hostWdata;
					end
					// [R15] Drive bit ignored
					atf_pkg::ADDR_DRIVE_HEAD:
						cur_reg.driveHead <= hostWdata & ~(8'h01 << atf_pkg::HEAD_DRIVE_BIT);
					default: ;
				endcase
			end
			if (state_reg == ATF_IDLE && wrCmd) begin
				code_reg <= hostWdata;
				if (abortLock || abortLimit) begin
					error_reg  <= 8'h01 << atf_pkg::ERR_ABORT_BIT;
					status_reg <= 8'h51;
					pend_reg   <= 1'b1;
					frame_reg  <= 1'b1;
				end else if (powerQuery) begin
					cur_reg.count <= powerAnswer;
					error_reg  <= 8'h00;
					status_reg <= atf_pkg::RESET_STATUS;
					pend_reg   <= 1'b1;
					frame_reg  <= 1'b1;
				end else begin
					// [R8] Start on code write
					start_reg  <= 1'b1;
					status_reg <= 8'hD0;
				end
			end else if (state_reg == ATF_BUSY && cmdDone) begin
				// [R26] Final image to host
				// [R9] [R10] [R16] Address updated
				cur_reg           <= cmdResult.final_;
				// [R21] Remaining count
				cur_reg.count     <= cmdResult.success ? 8'h00 : cmdResult.final_.count;
				cur_reg.driveHead <= (cmdResult.final_.driveHead
				                     & ~(8'h01 << atf_pkg::HEAD_DRIVE_BIT));
				// [R17] [R19] Valid error, AMNF zero
				if (code_reg != atf_pkg::CMD_DIAGNOSTIC)
					error_reg <= cmdResult.errorBits & atf_pkg::ERROR_VALID_MASK;
				else
					error_reg <= diagCode;
				// [R23] DF, CORR forced zero
				status_reg <= cmdResult.statusBits & 8'h5B & 8'h7F;
				pend_reg   <= 1'b1;
				frame_reg  <= 1'b1;
			end else if (rdStatus) begin
				// [R24] Read acknowledges
				pend_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// [R20] Zero count expansion
	wire logic is48 = cmdCode == 8'h24 || cmdCode == 8'h25 || cmdCode == 8'h34 || cmdCode == 8'h35;
	wire logic [15:0] rawCount = is48 ? {prev_reg.count, cur_reg.count} : {8'h00, cur_reg.count};
	assign sectorsRequested = rawCount == 16'h0000 ? (is48 ? 17'h10000 : 17'h00100)
	                          : {1'b0, rawCount};

	// [R4] Streaming floor
	assign streamLimitUsedMs = streamLimitMs < 16'(atf_pkg::STREAM_MIN_MS) ?
	                           16'(atf_pkg::STREAM_MIN_MS) : streamLimitMs;
	assign spinupOverrun = spinningUp && state_reg == ATF_BUSY;

	// [R3] Grace window after power-on
	assign cominitLateOk = grace_reg != $bits(grace_reg)'(GRACE_CYCLES);

	// [R14] Gated interrupt
	assign intrq = pend_reg && !ctrl_reg[atf_pkg::CTRL_IRQ_DISABLE_BIT] && deviceSelected;

	// [R6] Host side sets busy on its own copy
	assign frameToHost = frame_reg;
	assign cmdStart    = start_reg;
	assign cmdCode     = code_reg;
	assign cmdParam    = feat_reg;
	assign cmdAddr     = cur_reg;
	assign lbaMode     = cur_reg.driveHead[atf_pkg::HEAD_ADDR_MODE_BIT];
	assign inSoftReset = state_reg == ATF_RST;

endmodule : atf_task_file

//--- tb/atf_task_file_props.sv
// Checker for the task-file block, bound to its ports.
// Assumes one-cycle host strobes and cmdDone only while busy.
`timescale 1ns/1ps
module atf_task_file_props #(
	parameter int GRACE_CYCLES = 100
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        linkReset,
	input wire logic        hostWrite,
	input wire logic        hostRead,
	input wire logic [3:0]  hostAddr,
	input wire logic [7:0]  hostWdata,
	input wire logic        securityLocked,
	input wire logic [7:0]  recoveryLimit100ms,
	input wire logic        recoveryLimitGiven,
	input wire logic        cmdDone,
	input wire logic        deviceSelected,
	input wire logic        cmdStart,
	input wire logic [7:0]  cmdCode,
	input wire logic [15:0] streamLimitUsedMs,
	input wire logic        inSoftReset,
	input wire logic        intrq,
	input wire logic        cominitLateOk,
	input wire logic        frameToHost
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic cmdWr = hostWrite && hostAddr == atf_pkg::ADDR_COMMAND_CODE;
	wire logic ctlWr = hostWrite && hostAddr == atf_pkg::ADDR_INTERFACE_CTRL;
	wire logic srBit = hostWdata[atf_pkg::CTRL_SOFT_RESET_BIT];
	wire logic dlCode = hostWdata == atf_pkg::CMD_DOWNLOAD_PIO
		|| hostWdata == atf_pkg::CMD_DOWNLOAD_DMA;
	AST_START_CAUSE: assert property (cmdStart |-> $past(cmdWr) && cmdCode == $past(hostWdata))
		else $error("start without command write");
	AST_DL_LOCKED: assert property (cmdWr && dlCode && securityLocked |=> !cmdStart)
		else $error("download started while locked");
	AST_RECOVERY: assert property (cmdWr && recoveryLimitGiven && recoveryLimit100ms < 8'h41 |=> !cmdStart)
		else $error("short recovery limit accepted");
	AST_STREAM_MIN: assert property (streamLimitUsedMs >= 16'h0032)
		else $error("stream limit under floor");
	AST_IRQ_SEL: assert property (intrq |-> deviceSelected)
		else $error("interrupt while not selected");
	AST_STATUS_ACK: assert property (hostRead && hostAddr == atf_pkg::ADDR_STATUS && !cmdDone |=> !intrq)
		else $error("status read left interrupt");
	AST_MIRROR_KEEP: assert property (hostRead && hostAddr == atf_pkg::ADDR_MIRROR_STATUS && intrq
		&& !linkReset && !inSoftReset |=> intrq || !deviceSelected)
		else $error("mirror read cleared interrupt");
	AST_SOFT_RESET: assert property (ctlWr && !linkReset |=> ##1 inSoftReset == $past(srBit, 2))
		else $error("soft reset state wrong");
	AST_DONE_FRAME: assert property (cmdDone && !linkReset && !inSoftReset |=> frameToHost)
		else $error("no frame after completion");
	AST_GRACE: assert property ($fell(reset) |=> cominitLateOk [*8])
		else $error("grace window not open");
endmodule : atf_task_file_props

bind atf_task_file atf_task_file_props #(.GRACE_CYCLES(GRACE_CYCLES)) i_props (
	.clk, .reset, .linkReset, .hostWrite, .hostRead, .hostAddr, .hostWdata,
	.securityLocked, .recoveryLimit100ms, .recoveryLimitGiven, .cmdDone,
	.deviceSelected, .cmdStart, .cmdCode, .streamLimitUsedMs, .inSoftReset,
	.intrq, .cominitLateOk, .frameToHost
);

//--- tb/atf_host_model.sv
// Host adapter model: register accesses and the shadow busy bit.
// Assumes one access at a time, launched just after a rising edge.
`timescale 1ns/1ps
module atf_host_model (
	input  wire logic       clk,
	output logic            hostWrite,
	output logic            hostRead,
	output logic      [3:0] hostAddr,
	output logic      [7:0] hostWdata,
	input  wire logic [7:0] hostRdata,
	input  wire logic       frameToHost
);
	logic shadowBusy = 1'b0;
	logic srLast     = 1'b0;
	initial begin
		hostWrite = 1'b0;
		hostRead = 1'b0;
		hostAddr = 4'h0;
		hostWdata = 8'h00;
	end
	// busy on command or reset change
	always @(posedge clk) begin
		if (frameToHost)
			shadowBusy <= 1'b0;
		if (hostWrite && (hostAddr == 4'h7 || (hostAddr == 4'hE && hostWdata[2] != srLast)))
			shadowBusy <= 1'b1;
		if (hostWrite && hostAddr == 4'hE)
			srLast <= hostWdata[2];
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		hostWrite <= 1'b1;
		hostAddr <= a;
		hostWdata <= d;
		@(posedge clk);
		hostWrite <= 1'b0;
		hostWdata <= ~d;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		hostRead <= 1'b1;
		hostAddr <= a;
		@(posedge clk);
		hostRead <= 1'b0;
		#1;
		d = hostRdata;
	endtask : rd
endmodule : atf_host_model

//--- tb/atf_task_file_tb_top.sv
// Self-checking bench for the task-file block.
// Assumes the host model and the bound checker sit beside it.
`timescale 1ns/1ps
module atf_task_file_tb_top;
	logic                clk = 1'b0;
	logic                reset = 1'b1;
	logic                linkReset = 1'b0;
	logic                hostWrite, hostRead;
	logic [3:0]          hostAddr;
	logic [7:0]          hostWdata, hostRdata, cmdCode, cmdParam, d;
	logic                epcEnabled = 1'b0;
	logic                deviceIdle = 1'b0;
	logic                securityLocked = 1'b0;
	logic                spinningUp = 1'b0;
	logic [15:0]         streamLimitMs = 16'h0064;
	logic [15:0]         streamLimitUsedMs;
	logic [7:0]          recoveryLimit100ms = 8'h41;
	logic                recoveryLimitGiven = 1'b0;
	logic                cmdDone = 1'b0;
	atf_pkg::atf_done_t  cmdResult = '0;
	logic [7:0]          diagCode = 8'h01;
	logic                deviceSelected = 1'b1;
	logic                cmdStart, lbaMode, inSoftReset, intrq, cominitLateOk, frameToHost;
	atf_pkg::atf_addr_t  cmdAddr;
	logic [16:0]         sectorsRequested;
	int                  mismatches = 0;
	int                  n_checks = 0;
	int                  cycleCount = 0;
	logic [3:0]          rAddr [7] = '{4'h7, 4'hE, 4'h2, 4'h3, 4'h4, 4'h5, 4'h1};
	logic [7:0]          rVal [7] = '{8'h50, 8'h50, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
	logic [15:0]         sIn [4] = '{16'h000A, 16'h0031, 16'h0032, 16'h00C8};
	logic [15:0]         sOut [4] = '{16'h0032, 16'h0032, 16'h0032, 16'h00C8};

	always #10 clk = ~clk;

	atf_host_model i_host (.clk, .hostWrite, .hostRead, .hostAddr, .hostWdata, .hostRdata,
		.frameToHost);
	atf_task_file #(.GRACE_CYCLES(100), .COMINIT_CYCLES(50)) i_dut (.clk, .reset, .linkReset,
		.hostWrite, .hostRead, .hostAddr, .hostWdata, .hostRdata, .epcEnabled, .deviceIdle,
		.securityLocked, .spinningUp, .streamLimitMs, .recoveryLimit100ms, .recoveryLimitGiven,
		.cmdDone, .cmdResult, .diagCode, .deviceSelected, .cmdStart, .cmdCode, .cmdParam,
		.cmdAddr, .sectorsRequested, .lbaMode, .streamLimitUsedMs, .spinupOverrun(),
		.inSoftReset, .intrq, .cominitLateOk, .frameToHost);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		i_host.rd(a, d);
		chk(d, exp);
	endtask : rchk
	task automatic done(input logic ok, input logic [7:0] err, input logic [7:0] st,
		input logic [7:0] cnt);
		@(posedge clk);
		cmdDone <= 1'b1;
		cmdResult <= {ok, err, st, cnt, 8'h09, 8'h12, 8'h34, 8'h47};
		@(posedge clk);
		cmdDone <= 1'b0;
		#1;
		chk(frameToHost, 1);
	endtask : done
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk) begin
		cycleCount++;
		if (cycleCount == 20000) begin
			mismatches++;
			close_out();
		end
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		chk(cominitLateOk, 1);
		for (int i = 0; i < 7; i++) rchk(rAddr[i], rVal[i]);
		i_host.wr(4'h6, 8'h45);
		rchk(4'h6, 8'hE5);
		chk(lbaMode, 1);
		// Previous then current bytes, high-byte select
		i_host.wr(4'h5, 8'h11);
		i_host.wr(4'h5, 8'h22);
		i_host.wr(4'h4, 8'h33);
		i_host.wr(4'h4, 8'h44);
		i_host.wr(4'hE, 8'h80);
		rchk(4'h5, 8'h11);
		rchk(4'h4, 8'h33);
		i_host.wr(4'h2, 8'h08);
		rchk(4'h5, 8'h22);
		i_host.wr(4'h6, 8'h40);
		i_host.wr(4'h1, 8'h5A);
		i_host.wr(4'h7, 8'hC8);
		#1;
		chk({cmdStart, cmdCode, cmdParam, cmdAddr.count}, {1'b1, 24'hC85A08});
		chk(i_host.shadowBusy, 1);
		i_host.rd(4'hE, d);
		chk(d[7], 1);
		done(1'b1, 8'h00, 8'h50, 8'h00);
		chk(intrq, 1);
		rchk(4'hE, 8'h50);
		chk(intrq, 1);
		chk(i_host.shadowBusy, 0);
		rchk(4'h2, 8'h00);
		rchk(4'h4, 8'h12);
		rchk(4'h5, 8'h34);
		rchk(4'h6, 8'hE7);
		rchk(4'h1, 8'h00);
		rchk(4'h7, 8'h50);
		chk(intrq, 0);
		// Failing command with interrupts disabled
		i_host.wr(4'hE, 8'h02);
		i_host.wr(4'h7, 8'hC8);
		done(1'b0, 8'hFF, 8'h51, 8'h03);
		chk(intrq, 0);
		rchk(4'h1, 8'hD6);
		rchk(4'h2, 8'h03);
		rchk(4'h7, 8'h51);
		@(posedge clk) securityLocked <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			i_host.wr(4'h7, 8'h92 + 8'(i));
			#1;
			chk({cmdStart, frameToHost}, 2'b01);
			rchk(4'h1, 8'h04);
		end
		@(posedge clk) securityLocked <= 1'b0;
		@(posedge clk) recoveryLimitGiven <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) recoveryLimit100ms <= 8'h40 + 8'(i);
			i_host.wr(4'h7, 8'hC8);
			#1;
			chk(cmdStart, 32'(i));
			if (i == 1) done(1'b1, 8'h00, 8'h50, 8'h00);
			else rchk(4'h1, 8'h04);
		end
		@(posedge clk) recoveryLimitGiven <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) streamLimitMs <= sIn[i];
			@(posedge clk) #1 chk(streamLimitUsedMs, sOut[i]);
		end
		@(posedge clk) deviceIdle <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) epcEnabled <= i[0];
			i_host.wr(4'h7, atf_pkg::CMD_CHECK_POWER);
			rchk(4'h2, i ? 8'h80 : 8'hFF);
		end
		@(posedge clk) diagCode <= 8'h03;
		i_host.wr(4'hE, 8'h04);
		@(posedge clk) #1;
		chk(inSoftReset, 1);
		// hold the bit over 5 us
		repeat (260) @(posedge clk);
		i_host.wr(4'hE, 8'h00);
		@(posedge clk) #1;
		chk(inSoftReset, 0);
		rchk(4'h1, 8'h03);
		rchk(4'h2, 8'h01);
		@(posedge clk) linkReset <= 1'b1;
		@(posedge clk) linkReset <= 1'b0;
		rchk(4'h7, 8'h50);
		chk(cominitLateOk, 0);
		close_out();
	end
endmodule : atf_task_file_tb_top
